/* File: idc_bank.sv */
// Identification and capability word bank with AXI4-Lite register access
//
// Summary of operation
// - Power-level word low byte shows the current power management level.
// - Security word bit 8 is one for maximum level, zero for high; here it reads zero while security is disabled.
// - Security word bit 5 shows enhanced erase-unit support.
// - Expired count sets bit 4; unlock and erase abort until reset.
// - Security word bit 3 shows frozen, bit 2 shows locked.
// - Security word bit 1 shows security enabled.
// - Security word bit 0 shows security feature set supported.
// - Power word bit 15 marks valid description; bit 14 reads zero.
// - Power word bit 13: no level-one commands; bit 12: they're disabled.
// - Power word low twelve bits hold maximum current in milliamperes.
// - Key word bit 0 shows key scheme support; bits 1-15 reserved.
// - Timing word bits 2-0 give maximum advanced PIO mode.
// - Timing word bits 5-3 give maximum advanced multiword DMA mode.
// - Timing word bits 8-6 report selected PIO mode.
// - Timing word bits 11-9 report selected DMA mode; 15-12 reserved.
// - Bus timing bits 2-0 give fastest I/O cycle code.
// - Bus timing bits 5-3 give fastest memory cycle; 15-6 reserved.
// - Host picks health subcommand by feature value; device decodes it.
// - Return-status puts spare-below-threshold answer in cylinder value.
// - Never select an Ultra DMA and multiword DMA mode together.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`include "idc_map.svh"

module idc_bank
  import idc_pkg::*;
#(
  parameter logic [2:0] PIO_CAP = 3'h2,
  parameter logic [2:0] MW_CAP = 3'h2,
  parameter logic [2:0] IO_CAP = 3'h3,
  parameter logic [2:0] MEM_CAP = 3'h3,
  parameter logic [11:0] MAX_CURRENT = 12'h064,
  parameter logic SEC_SUPPORTED = 1'b1,
  parameter logic ENH_ERASE = 1'b1,
  parameter logic KEY_SCHEME = 1'b0,
  parameter logic PWR_VALID = 1'b1,
  parameter logic NO_LEVEL_ONE = 1'b0,
  parameter logic [3:0] ATTEMPTS = `IDC_RST_ATTEMPTS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input idc_axi_req_t axi_req,
  output idc_axi_rsp_t axi_rsp
);

  // Reserved encodings cannot be advertised as capability
  if (PIO_CAP > 3'h2) begin : g_bad_pio
    $error("PIO_CAP above 2 is reserved");
  end
  if (MW_CAP > 3'h2) begin : g_bad_mw
    $error("MW_CAP above 2 is reserved");
  end
  if (IO_CAP > 3'h3 || MEM_CAP > 3'h3) begin : g_bad_bus
    $error("bus timing codes above 3 are reserved");
  end
  if (ATTEMPTS == 4'h0) begin : g_bad_att
    $error("ATTEMPTS must be at least one");
  end

  idc_state_t s_q;
  idc_state_t s_d;
  logic [15:0] w_apm;
  logic [15:0] w_sec;
  logic [15:0] w_pwr;
  logic [15:0] w_key;
  logic [15:0] w_adv;
  logic [15:0] w_bus;
  logic [15:0] w_idx;
  logic [2:0] pio_rep;
  logic [2:0] mw_rep;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic [7:0] op;
  logic [7:0] feat;

  // Handshakes: one write and one read in flight at a time
  assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
  assign axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.bvalid = s_q.bvalid;
  assign axi_rsp.bresp = s_q.bresp;
  assign axi_rsp.rvalid = s_q.rvalid;
  assign axi_rsp.rdata = s_q.rdata;
  assign axi_rsp.rresp = s_q.rresp;
  assign aw_hs = axi_req.awvalid && axi_rsp.awready;
  assign w_hs = axi_req.wvalid && axi_rsp.wready;
  assign ar_hs = axi_req.arvalid && axi_rsp.arready;
  // Write acts once both halves are held, whatever order they came in
  assign do_write = s_q.aw_got && s_q.w_got;
  assign op = s_q.wdata[`IDC_CMD_OP_LSB +: 8];
  assign feat = s_q.wdata[`IDC_CMD_FEAT_LSB +: 8];

  // Selected PIO mode reads as zero unless legal, multiword DMA mode unless legal and active
  always_comb begin
    pio_rep = (s_q.mode.pio_sel <= PIO_CAP) ? s_q.mode.pio_sel : 3'h0;
    mw_rep = (s_q.mode.mw_on && !s_q.mode.udma_on &&
              s_q.mode.mw_sel <= MW_CAP) ? s_q.mode.mw_sel : 3'h0;
  end

  // The six identification words; key and bus words are fixed, the rest built from live state
  always_comb begin
    w_apm = {8'h00, s_q.cfg.apm_level};
    w_sec = {7'h00, s_q.cfg.sec_enabled && s_q.cfg.sec_max, 2'b00,
             ENH_ERASE, s_q.expired, s_q.cfg.sec_frozen,
             s_q.cfg.sec_locked, s_q.cfg.sec_enabled, SEC_SUPPORTED};
    w_pwr = {PWR_VALID, 1'b0, NO_LEVEL_ONE,
             s_q.cfg.level_one_power_cmds_disabled, MAX_CURRENT};
    w_key = {15'h0000, KEY_SCHEME};
    w_adv = {4'h0, mw_rep, pio_rep, MW_CAP, PIO_CAP};
    w_bus = {10'h000, MEM_CAP, IO_CAP};
  end

  // word picked by the identify pointer
  always_comb begin
    case (s_q.idx)
      `IDC_IDX_APM: w_idx = w_apm;
      `IDC_IDX_SEC: w_idx = w_sec;
      `IDC_IDX_PWR: w_idx = w_pwr;
      `IDC_IDX_KEY: w_idx = w_key;
      `IDC_IDX_ADV: w_idx = w_adv;
      `IDC_IDX_BUS: w_idx = w_bus;
      default: w_idx = 16'h0000;
    endcase
  end

  // Next state: bus slave, commands and identify streaming
  always_comb begin
    s_d = s_q;
    // Capture address and data halves
    if (aw_hs) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (w_hs) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `IDC_RESP_OKAY;
      case (s_q.awaddr)
        `IDC_OFF_CFG: begin
          if (s_q.wstrb[0]) begin
            s_d.cfg.apm_level = s_q.wdata[7:0];
          end
          if (s_q.wstrb[1]) begin
            s_d.cfg.sec_max = s_q.wdata[8];
            s_d.cfg.sec_enabled = s_q.wdata[9] && SEC_SUPPORTED;
            s_d.cfg.sec_frozen = s_q.wdata[10];
            s_d.cfg.sec_locked = s_q.wdata[11];
            s_d.cfg.level_one_power_cmds_disabled = s_q.wdata[12];
            s_d.cfg.spare_below = s_q.wdata[13];
          end
        end
        `IDC_OFF_MODE: begin
          if (s_q.wstrb[0]) begin
            s_d.mode.pio_sel = s_q.wdata[2:0];
            s_d.mode.mw_sel = s_q.wdata[5:3];
          end
          if (s_q.wstrb[1]) begin
            s_d.mode.udma_sel = {s_q.wdata[8:7], s_q.wdata[6]};
            s_d.mode.udma_on = s_q.wdata[9];
            s_d.mode.mw_on = s_q.wdata[10] && !s_q.wdata[9];
          end
        end
        `IDC_OFF_CMD: begin
          if (s_q.wstrb[0]) begin
            s_d.abort = 1'b0;
            case (op)
              `IDC_CMD_IDENTIFY: begin
                s_d.xfer = IDC_XF_BUSY;
                s_d.idx = 8'h00;
              end
              `IDC_CMD_UNLOCK: begin
                if (s_q.expired) begin
                  s_d.abort = 1'b1;
                end else if (s_q.wdata[`IDC_CMD_PWOK_BIT]) begin
                  s_d.cfg.sec_locked = 1'b0;
                end else begin
                  s_d.abort = 1'b1;
                  s_d.attempts = s_q.attempts - 4'h1;
                  if (s_q.attempts == 4'h1) begin
                    s_d.expired = 1'b1;
                  end
                end
              end
              `IDC_CMD_ERASE: begin
                if (s_q.expired || !s_q.wdata[`IDC_CMD_PWOK_BIT]) begin
                  s_d.abort = 1'b1;
                end else begin
                  s_d.cfg.sec_locked = 1'b0;
                  s_d.cfg.sec_enabled = 1'b0;
                  s_d.cfg.sec_max = 1'b0;
                end
              end
              `IDC_CMD_SMART: begin
                case (feat)
                  `IDC_SM_READ_DATA: s_d.sub = IDC_SUB_READ_DATA;
                  `IDC_SM_READ_THR: s_d.sub = IDC_SUB_READ_THR;
                  `IDC_SM_AUTOSAVE: s_d.sub = IDC_SUB_AUTOSAVE;
                  `IDC_SM_SAVE_ATTR: s_d.sub = IDC_SUB_SAVE_ATTR;
                  `IDC_SM_OFFLINE: s_d.sub = IDC_SUB_OFFLINE;
                  `IDC_SM_READ_LOG: s_d.sub = IDC_SUB_READ_LOG;
                  `IDC_SM_WRITE_LOG: s_d.sub = IDC_SUB_WRITE_LOG;
                  `IDC_SM_ENABLE: s_d.sub = IDC_SUB_ENABLE;
                  `IDC_SM_DISABLE: s_d.sub = IDC_SUB_DISABLE;
                  `IDC_SM_STATUS: s_d.sub = IDC_SUB_STATUS;
                  default: begin
                    s_d.sub = IDC_SUB_NONE;
                    s_d.abort = 1'b1;
                  end
                endcase
                if (feat == `IDC_SM_STATUS) begin
                  s_d.cyl = s_q.cfg.spare_below ? `IDC_CYL_BELOW
                                                : `IDC_CYL_GOOD;
                end
              end
              default: s_d.abort = 1'b1;
            endcase
          end
        end
        `IDC_OFF_STAT, `IDC_OFF_DATA, `IDC_OFF_APM, `IDC_OFF_SEC,
        `IDC_OFF_PWR, `IDC_OFF_KEY, `IDC_OFF_ADV, `IDC_OFF_BUS: begin
          // Read-only words ignore writes
          s_d.bresp = `IDC_RESP_OKAY;
        end
        default: s_d.bresp = `IDC_RESP_SLVERR;
      endcase
    end
    // Read channel
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `IDC_RESP_OKAY;
      case (axi_req.araddr)
        `IDC_OFF_CFG: s_d.rdata = {18'h00000, s_q.cfg.spare_below,
            s_q.cfg.level_one_power_cmds_disabled, s_q.cfg.sec_locked,
            s_q.cfg.sec_frozen, s_q.cfg.sec_enabled, s_q.cfg.sec_max,
            s_q.cfg.apm_level};
        `IDC_OFF_MODE: s_d.rdata = {21'h000000, s_q.mode.mw_on,
                                    s_q.mode.udma_on, s_q.mode.udma_sel,
                                    s_q.mode.mw_sel, s_q.mode.pio_sel};
        `IDC_OFF_CMD: s_d.rdata = 32'h0000_0000;
        `IDC_OFF_STAT: s_d.rdata = {s_q.cyl, 8'h00, s_q.sub, 1'b0,
                                    s_q.expired, s_q.xfer == IDC_XF_BUSY,
                                    s_q.abort};
        `IDC_OFF_DATA: begin
          // each data read during an identify transfer moves the pointer on
          if (s_q.xfer == IDC_XF_BUSY) begin
            s_d.rdata = {16'h0000, w_idx};
            s_d.idx = s_q.idx + 8'h01;
            if (s_q.idx == `IDC_IDX_LAST) begin
              s_d.xfer = IDC_XF_IDLE;
            end
          end else begin
            s_d.rdata = 32'h0000_0000;
          end
        end
        `IDC_OFF_APM: s_d.rdata = {16'h0000, w_apm};
        `IDC_OFF_SEC: s_d.rdata = {16'h0000, w_sec};
        `IDC_OFF_PWR: s_d.rdata = {16'h0000, w_pwr};
        `IDC_OFF_KEY: s_d.rdata = {16'h0000, w_key};
        `IDC_OFF_ADV: s_d.rdata = {16'h0000, w_adv};
        `IDC_OFF_BUS: s_d.rdata = {16'h0000, w_bus};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `IDC_RESP_SLVERR;
        end
      endcase
    end
  end

  // State register; expiry only leaves through reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.cfg <= `IDC_RST_CFG;
      s_q.mode <= `IDC_RST_MODE;
      s_q.attempts <= ATTEMPTS;
      s_q.cyl <= `IDC_CYL_GOOD;
      s_q.sub <= IDC_SUB_NONE;
      s_q.xfer <= IDC_XF_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Checks on the bank's behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Expired stays set until reset
  expire_sticky_a: assert property (s_q.expired |=> s_q.expired)
    else $error("expired flag dropped without reset");

  // Unlock while expired always aborts
  expire_abort_a: assert property (
    do_write && s_q.awaddr == `IDC_OFF_CMD && s_q.wstrb[0] &&
    op == `IDC_CMD_UNLOCK && s_q.expired
    |=> s_q.abort && s_q.cfg.sec_locked == $past(s_q.cfg.sec_locked))
    else $error("unlock not aborted after expiry");

  // Security word reflects state on a direct read
  sec_word_a: assert property (
    ar_hs && axi_req.araddr == `IDC_OFF_SEC
    |=> s_q.rdata[3] == $past(s_q.cfg.sec_frozen) &&
        s_q.rdata[2] == $past(s_q.cfg.sec_locked) &&
        s_q.rdata[4] == $past(s_q.expired) && s_q.rdata[0] == SEC_SUPPORTED)
    else $error("security word bits wrong");

  // Maximum-level bit needs security enabled
  sec_level_a: assert property (
    ar_hs && axi_req.araddr == `IDC_OFF_SEC && !s_q.cfg.sec_enabled
    |=> !s_q.rdata[8] && !s_q.rdata[1])
    else $error("level bit set with security off");

  // Power word layout
  pwr_word_a: assert property (
    ar_hs && axi_req.araddr == `IDC_OFF_PWR
    |=> s_q.rdata[14] == 1'b0 && s_q.rdata[11:0] == MAX_CURRENT &&
        s_q.rdata[15] == PWR_VALID && s_q.rdata[31:16] == 16'h0000)
    else $error("power word layout wrong");

  // Never both DMA kinds selected
  dma_excl_a: assert property (
    s_q.mode.udma_on |-> mw_rep == 3'h0 && w_adv[11:9] == 3'h0)
    else $error("two DMA modes reported selected");

  // Return-status answer in cylinder value
  smart_cyl_a: assert property (
    do_write && s_q.awaddr == `IDC_OFF_CMD && s_q.wstrb[0] &&
    op == `IDC_CMD_SMART && feat == `IDC_SM_STATUS
    |=> s_q.cyl == ($past(s_q.cfg.spare_below) ? `IDC_CYL_BELOW
                                                : `IDC_CYL_GOOD) &&
        s_q.sub == IDC_SUB_STATUS)
    else $error("return-status cylinder value wrong");

  // Identify stream places power level at its word
  ident_word_a: assert property (
    ar_hs && axi_req.araddr == `IDC_OFF_DATA &&
    s_q.xfer == IDC_XF_BUSY && s_q.idx == `IDC_IDX_APM
    |=> s_q.rdata == {24'h000000, $past(s_q.cfg.apm_level)} &&
        s_q.idx == 8'h5C)
    else $error("identify power-level word wrong");

  // Timing word capability fields
  adv_cap_a: assert property (
    ar_hs && axi_req.araddr == `IDC_OFF_ADV
    |=> s_q.rdata[2:0] == PIO_CAP && s_q.rdata[5:3] == MW_CAP &&
        s_q.rdata[15:12] == 4'h0)
    else $error("timing capability fields wrong");

  // Write answered two cycles after both halves are taken
  write_resp_a: assert property (
    aw_hs && w_hs |=> !s_q.bvalid ##1 s_q.bvalid)
    else $error("write response timing wrong");

  // Main scenarios
  cov_ident_done_c: cover property (
    s_q.xfer == IDC_XF_BUSY ##1 s_q.xfer == IDC_XF_IDLE);
  cov_expire_c: cover property (!s_q.expired ##1 s_q.expired);
  cov_smart_below_c: cover property (s_q.cyl == `IDC_CYL_BELOW);
  cov_unmapped_c: cover property (
    s_q.rvalid && s_q.rresp == `IDC_RESP_SLVERR);

endmodule : idc_bank

/* File: idc_map.svh */
// Offsets, field positions, reset values and codes of the identify word bank
`ifndef IDC_MAP_SVH
`define IDC_MAP_SVH

// Register byte offsets
`define IDC_OFF_CFG 8'h00
`define IDC_OFF_MODE 8'h04
`define IDC_OFF_CMD 8'h08
`define IDC_OFF_STAT 8'h0C
`define IDC_OFF_DATA 8'h10
`define IDC_OFF_APM 8'h20
`define IDC_OFF_SEC 8'h24
`define IDC_OFF_PWR 8'h28
`define IDC_OFF_KEY 8'h2C
`define IDC_OFF_ADV 8'h30
`define IDC_OFF_BUS 8'h34

// Word positions inside the identification block
`define IDC_IDX_APM 8'h5B
`define IDC_IDX_SEC 8'h80
`define IDC_IDX_PWR 8'hA0
`define IDC_IDX_KEY 8'hA2
`define IDC_IDX_ADV 8'hA3
`define IDC_IDX_BUS 8'hA4
`define IDC_IDX_LAST 8'hFF

// Command register fields
`define IDC_CMD_OP_LSB 0
`define IDC_CMD_FEAT_LSB 8
`define IDC_CMD_PWOK_BIT 16

// Command codes
`define IDC_CMD_IDENTIFY 8'hEC
`define IDC_CMD_UNLOCK 8'hF2
`define IDC_CMD_ERASE 8'hF4
`define IDC_CMD_SMART 8'hB0

// Feature values selecting the health subcommands
`define IDC_SM_READ_DATA 8'hD0
`define IDC_SM_READ_THR 8'hD1
`define IDC_SM_AUTOSAVE 8'hD2
`define IDC_SM_SAVE_ATTR 8'hD3
`define IDC_SM_OFFLINE 8'hD4
`define IDC_SM_READ_LOG 8'hD5
`define IDC_SM_WRITE_LOG 8'hD6
`define IDC_SM_ENABLE 8'hD8
`define IDC_SM_DISABLE 8'hD9
`define IDC_SM_STATUS 8'hDA

// Cylinder answers of the return-status subcommand
`define IDC_CYL_GOOD 16'hC24F
`define IDC_CYL_BELOW 16'h2CF4

// Reset values
`define IDC_RST_CFG 14'h0000
`define IDC_RST_MODE 11'h000
`define IDC_RST_ATTEMPTS 4'h5

// AXI responses
`define IDC_RESP_OKAY 2'b00
`define IDC_RESP_SLVERR 2'b10

`endif

/* File: idc_pkg.sv */
// Types of the identify word bank
package idc_pkg;

  typedef enum logic [3:0] {
    IDC_SUB_NONE, IDC_SUB_READ_DATA, IDC_SUB_READ_THR, IDC_SUB_AUTOSAVE,
    IDC_SUB_SAVE_ATTR, IDC_SUB_OFFLINE, IDC_SUB_READ_LOG, IDC_SUB_WRITE_LOG,
    IDC_SUB_ENABLE, IDC_SUB_DISABLE, IDC_SUB_STATUS
  } idc_sub_t;

  typedef enum logic {IDC_XF_IDLE, IDC_XF_BUSY} idc_xfer_t;

  typedef struct packed {
    logic [7:0] apm_level;
    logic sec_max;
    logic sec_enabled;
    logic sec_frozen;
    logic sec_locked;
    logic level_one_power_cmds_disabled;
    logic spare_below;
  } idc_cfg_t;

  typedef struct packed {
    logic [2:0] pio_sel;
    logic [2:0] mw_sel;
    logic [2:0] udma_sel;
    logic udma_on;
    logic mw_on;
  } idc_mode_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } idc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } idc_axi_rsp_t;

  typedef struct packed {
    idc_cfg_t cfg;
    idc_mode_t mode;
    logic expired;
    logic [3:0] attempts;
    logic abort;
    idc_sub_t sub;
    logic [15:0] cyl;
    idc_xfer_t xfer;
    logic [7:0] idx;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } idc_state_t;

endpackage : idc_pkg

/* File: idc_host.sv */
// Host-side bus master model for the identify word bank
module idc_host
  import idc_pkg::*;
(
  input wire logic ref_clk,
  input idc_axi_rsp_t rsp,
  output idc_axi_req_t req
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idle from time zero, nothing offered before reset lifts
  initial begin
    req = '0;
  end

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge ref_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!hb) begin
      // Sampled mid-cycle: readys and valids only move on rising edges
      @(negedge ref_clk);
      ha = req.awvalid & rsp.awready;
      hw = req.wvalid & rsp.wready;
      hb = rsp.bvalid;
      r = rsp.bresp;
      @(posedge ref_clk);
      req.awvalid <= req.awvalid & !ha;
      req.wvalid <= req.wvalid & !hw;
      // Released data lines must not keep the old value
      req.wdata <= hw ? ~d : req.wdata;
      req.bready <= !hb;
    end
  endtask : wr

  // Read: address held until taken, rready held until the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hr;
    hr = 1'b0;
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!hr) begin
      @(negedge ref_clk);
      ha = req.arvalid & rsp.arready;
      hr = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge ref_clk);
      req.arvalid <= req.arvalid & !ha;
      req.rready <= !hr;
    end
  endtask : rd
endmodule : idc_host

/* File: testbench.sv */
// Self-checking bench for the identify word bank and its command decoding
`include "idc_map.svh"

`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((e) !== (g)) begin \
      bad_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end

module testbench
  import idc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk;
  logic rst;
  idc_axi_req_t axi_req;
  idc_axi_rsp_t axi_rsp;
  int bad_count = 0;
  int n_compared = 0;
  logic [1:0] resp;
  logic [31:0] rdat;
  logic [7:0] feats [10];

  idc_bank u_idc_bank (.ref_clk(ref_clk), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp));
  idc_host u_idc_host (.ref_clk(ref_clk), .rsp(axi_rsp), .req(axi_req));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Expected identify words for CFG 0x1F80, default capabilities
  function automatic logic [15:0] idw(input int i);
    case (i)
      91: return 16'h0080;
      128: return 16'h012F;
      160: return 16'h9064;
      163: return 16'h0012;
      164: return 16'h001B;
      default: return 16'h0000;
    endcase
  endfunction : idw

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    u_idc_host.rd(a, rdat, resp);
    `CHK($sformatf("read %h", a), e, rdat)
    `CHK($sformatf("rresp %h", a), `IDC_RESP_OKAY, resp)
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_idc_host.wr(a, d, resp);
    `CHK($sformatf("bresp %h", a), `IDC_RESP_OKAY, resp)
  endtask : wr

  task automatic cmd(input logic [7:0] op, input logic [7:0] ft,
                     input logic ok);
    wr(`IDC_OFF_CMD, {15'h0000, ok, ft, op});
  endtask : cmd

  // Reset held four cycles; doubles as the hard reset that clears expiry
  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    feats = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD8,
              8'hD9, 8'hDA};
    do_reset();
    // Identification words straight out of reset
    rd_chk(`IDC_OFF_APM, 32'h0000_0000);
    rd_chk(`IDC_OFF_SEC, 32'h0000_0021);
    rd_chk(`IDC_OFF_PWR, 32'h0000_8064);
    rd_chk(`IDC_OFF_KEY, 32'h0000_0000);
    rd_chk(`IDC_OFF_ADV, 32'h0000_0012);
    rd_chk(`IDC_OFF_BUS, 32'h0000_001B);
    // all security states on at once
    wr(`IDC_OFF_CFG, 32'h0000_1F80);
    rd_chk(`IDC_OFF_APM, 32'h0000_0080);
    rd_chk(`IDC_OFF_SEC, 32'h0000_012F);
    rd_chk(`IDC_OFF_PWR, 32'h0000_9064);
    rd_chk(`IDC_OFF_CFG, 32'h0000_1F80);
    // whole identify block, then the idle stream
    cmd(`IDC_CMD_IDENTIFY, 8'h00, 1'b0);
    rd_chk(`IDC_OFF_STAT, 32'hC24F_0002);
    for (int i = 0; i < 256; i++) begin
      rd_chk(`IDC_OFF_DATA, {16'h0000, idw(i)});
    end
    rd_chk(`IDC_OFF_DATA, 32'h0000_0000);
    rd_chk(`IDC_OFF_STAT, 32'hC24F_0000);
    // Maximum level: bit 8 clear once security is off
    wr(`IDC_OFF_CFG, 32'h0000_0180);
    rd_chk(`IDC_OFF_SEC, 32'h0000_0021);
    // Enabled at high level: bit 8 stays clear, bit 1 set
    wr(`IDC_OFF_CFG, 32'h0000_0200);
    rd_chk(`IDC_OFF_SEC, 32'h0000_0023);
    // selected modes, udma beating multiword, over-cap selection
    wr(`IDC_OFF_MODE, 32'h0000_040A);
    rd_chk(`IDC_OFF_ADV, 32'h0000_0292);
    wr(`IDC_OFF_MODE, 32'h0000_060A);
    rd_chk(`IDC_OFF_ADV, 32'h0000_0092);
    rd_chk(`IDC_OFF_MODE, 32'h0000_020A);
    wr(`IDC_OFF_MODE, 32'h0000_040B);
    rd_chk(`IDC_OFF_ADV, 32'h0000_0212);
    for (int k = 0; k < 10; k++) begin
      cmd(`IDC_CMD_SMART, feats[k], 1'b0);
      rd_chk(`IDC_OFF_STAT, {16'hC24F, 8'h00, 4'(k + 1), 4'h0});
    end
    wr(`IDC_OFF_CFG, 32'h0000_2000);
    cmd(`IDC_CMD_SMART, 8'hDA, 1'b0);
    rd_chk(`IDC_OFF_STAT, 32'h2CF4_00A0);
    cmd(`IDC_CMD_SMART, 8'hD7, 1'b0);
    rd_chk(`IDC_OFF_STAT, 32'h2CF4_0001);
    // count runs out on the fifth failed unlock
    wr(`IDC_OFF_CFG, 32'h0000_0800);
    for (int k = 0; k < 5; k++) begin
      cmd(`IDC_CMD_UNLOCK, 8'h00, 1'b0);
      u_idc_host.rd(`IDC_OFF_STAT, rdat, resp);
      `CHK("expired", 3'(k == 4 ? 5 : 1), rdat[2:0])
    end
    rd_chk(`IDC_OFF_SEC, 32'h0000_0035);
    cmd(`IDC_CMD_UNLOCK, 8'h00, 1'b1);
    u_idc_host.rd(`IDC_OFF_STAT, rdat, resp);
    `CHK("unlock aborted", 3'h5, rdat[2:0])
    cmd(`IDC_CMD_ERASE, 8'h00, 1'b1);
    u_idc_host.rd(`IDC_OFF_STAT, rdat, resp);
    `CHK("erase aborted", 3'h5, rdat[2:0])
    rd_chk(`IDC_OFF_SEC, 32'h0000_0035);
    // Hard reset clears expiry
    do_reset();
    rd_chk(`IDC_OFF_STAT, 32'hC24F_0000);
    // Good unlock clears lock, good erase drops security
    wr(`IDC_OFF_CFG, 32'h0000_0B00);
    rd_chk(`IDC_OFF_SEC, 32'h0000_0127);
    cmd(`IDC_CMD_UNLOCK, 8'h00, 1'b1);
    rd_chk(`IDC_OFF_SEC, 32'h0000_0123);
    cmd(`IDC_CMD_ERASE, 8'h00, 1'b1);
    rd_chk(`IDC_OFF_SEC, 32'h0000_0021);
    rd_chk(`IDC_OFF_STAT, 32'hC24F_0000);
    // Read-only word ignores writes; unmapped places refused
    wr(`IDC_OFF_SEC, 32'h0000_0000);
    rd_chk(`IDC_OFF_SEC, 32'h0000_0021);
    u_idc_host.rd(8'h40, rdat, resp);
    `CHK("unmapped rresp", `IDC_RESP_SLVERR, resp)
    `CHK("unmapped rdata", 32'h0000_0000, rdat)
    u_idc_host.wr(8'h40, 32'h0000_00FF, resp);
    `CHK("unmapped bresp", `IDC_RESP_SLVERR, resp)
    rd_chk(`IDC_OFF_BUS, 32'h0000_001B);
    report_and_stop();
  end
endmodule : testbench
